/* rtl/isx_exec.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - increment-skip adds one to addressed file register
// - destination bit 0 to work, 1 to file
// - zero sum squashes next instruction as no-op
// - or-with-file ORs work and file, one cycle
// - or-with-literal ORs work with literal
// - or-with-literal always writes work register
// - load-literal copies literal into work register
// - load-literal don't-care bits ignored, emitted zero
module isx_exec (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic insn_valid,
  input wire logic [isx_pkg::INSN_W-1:0] insn,
  input wire logic [isx_pkg::DATA_W-1:0] file_rdata,
  output logic [isx_pkg::ADDR_W-1:0] file_raddr,
  output isx_pkg::isx_fwr_t file_wr,
  output logic [isx_pkg::DATA_W-1:0] work_q,
  output logic zero_q,
  output logic zero_we_q,
  output logic skip_q,
  output logic squash_q
);
  isx_pkg::isx_dec_t dec;
  isx_pkg::isx_fwr_t fwr_q;
  isx_pkg::isx_fwr_t fwr_d;
  logic [isx_pkg::DATA_W-1:0] work_d;
  logic [isx_pkg::DATA_W-1:0] result;
  logic zero_d;
  logic zero_we_d;
  logic skip_d;
  logic squash_d;
  logic exec;
  logic discard;
  logic result_zero;
  logic to_work;
  logic to_file;

  // all-zero test, shared by the skip and the zero flag
  function automatic logic is_zero(
    input logic [isx_pkg::DATA_W-1:0] v
  );
    return v == isx_pkg::ZERO_BYTE;
  endfunction

  // file-register operations steer their result by the destination bit
  function automatic logic has_dest(
    input isx_pkg::isx_op_t op
  );
    return (op == isx_pkg::OP_INC_SKIP) || (op == isx_pkg::OP_OR_FILE);
  endfunction

  // only the two OR forms touch the zero flag
  function automatic logic sets_zero(
    input isx_pkg::isx_op_t op
  );
    return (op == isx_pkg::OP_OR_FILE) || (op == isx_pkg::OP_OR_LIT);
  endfunction

  isx_decode u_dec (
    .insn(insn),
    .dec(dec)
  );

  // read address follows the fetched word combinationally so the file
  // space answers in the same cycle; registering it would cost a cycle
  assign file_raddr = dec.addr;
  assign file_wr = fwr_q;

  // a word fetched behind a taken skip is executed as a no-op
  assign discard = insn_valid && squash_q;
  assign exec = insn_valid && !squash_q;

  // result of the decoded operation
  always_comb begin
    result = isx_pkg::ZERO_BYTE;
    unique case (dec.op)
      isx_pkg::OP_INC_SKIP: begin
        result = file_rdata + isx_pkg::ONE_BYTE;
      end
      isx_pkg::OP_OR_FILE: begin
        result = work_q | file_rdata;
      end
      isx_pkg::OP_OR_LIT: begin
        result = work_q | dec.lit;
      end
      isx_pkg::OP_LOAD_LIT: begin
        result = dec.lit;
      end
      isx_pkg::OP_NONE: begin
        result = isx_pkg::ZERO_BYTE;
      end
    endcase
  end

  assign result_zero = is_zero(result);

  // destination steering for the file-register forms
  always_comb begin
    to_work = 1'b0;
    to_file = 1'b0;
    if (exec && has_dest(dec.op)) begin
      if (dec.dest == isx_pkg::DEST_WORK) begin
        to_work = 1'b1;
      end else begin
        to_file = 1'b1;
      end
    end
  end

  // working register group
  always_comb begin
    work_d = work_q;
    if (exec) begin
      unique case (dec.op)
        isx_pkg::OP_INC_SKIP,
        isx_pkg::OP_OR_FILE: begin
          if (to_work) begin
            work_d = result;
          end
        end
        isx_pkg::OP_OR_LIT: begin
          // no destination bit here: always the working register
          work_d = result;
        end
        isx_pkg::OP_LOAD_LIT: begin
          work_d = result;
        end
        isx_pkg::OP_NONE: begin
          work_d = work_q;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      work_q <= isx_pkg::WORK_RESET;
    end else if (ce) begin
      work_q <= work_d;
    end
  end

  // zero flag group; the write pulse lets the status owner merge it
  always_comb begin
    zero_d = zero_q;
    zero_we_d = 1'b0;
    if (exec && sets_zero(dec.op)) begin
      zero_d = result_zero;
      zero_we_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zero_q <= 1'b0;
      zero_we_q <= 1'b0;
    end else if (ce) begin
      zero_q <= zero_d;
      zero_we_q <= zero_we_d;
    end
  end

  // skip group: squash stays armed until a valid word arrives, so an
  // idle cycle between the skip and the next fetch cannot lose it
  always_comb begin
    skip_d = 1'b0;
    squash_d = squash_q;
    if (discard) begin
      squash_d = 1'b0;
    end else if (exec) begin
      if (dec.op == isx_pkg::OP_INC_SKIP) begin
        skip_d = result_zero;
        squash_d = result_zero;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_q <= 1'b0;
      squash_q <= 1'b0;
    end else if (ce) begin
      skip_q <= skip_d;
      squash_q <= squash_d;
    end
  end

  // file write group; we is high one enabled cycle per write and holds while ce is low
  always_comb begin
    fwr_d = '0;
    fwr_d.addr = dec.addr;
    if (to_file) begin
      fwr_d.we = 1'b1;
      fwr_d.data = result;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fwr_q <= '0;
    end else if (ce) begin
      fwr_q <= fwr_d;
    end
  end
endmodule
`default_nettype wire

/* pkg/isx_pkg.sv */
`default_nettype none
package isx_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned INSN_W = 14;

  // opcode top fields, compared against insn[13:8]
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  // load literal compares only insn[13:10]
  localparam logic [3:0] OPC_LOAD_LIT = 4'hc;

  localparam int unsigned DEST_BIT = 7;
  localparam logic DEST_WORK = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  localparam logic [DATA_W-1:0] WORK_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_INC_SKIP,
    OP_OR_FILE,
    OP_OR_LIT,
    OP_LOAD_LIT
  } isx_op_t;

  typedef struct packed {
    isx_op_t op;
    logic dest;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] lit;
  } isx_dec_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } isx_fwr_t;
endpackage
`default_nettype wire

/* rtl/isx_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module isx_decode (
  input wire logic [isx_pkg::INSN_W-1:0] insn,
  output isx_pkg::isx_dec_t dec
);
  always_comb begin
    dec.op = isx_pkg::OP_NONE;
    dec.dest = insn[isx_pkg::DEST_BIT];
    dec.addr = insn[isx_pkg::ADDR_W-1:0];
    dec.lit = insn[isx_pkg::DATA_W-1:0];
    if (insn[13:8] == isx_pkg::OPC_INC_SKIP) begin
      dec.op = isx_pkg::OP_INC_SKIP;
    end else if (insn[13:8] == isx_pkg::OPC_OR_FILE) begin
      dec.op = isx_pkg::OP_OR_FILE;
    end else if (insn[13:8] == isx_pkg::OPC_OR_LIT) begin
      dec.op = isx_pkg::OP_OR_LIT;
    end else if (insn[13:10] == isx_pkg::OPC_LOAD_LIT) begin
      // bits 9:8 are not looked at
      dec.op = isx_pkg::OP_LOAD_LIT;
    end
  end
endmodule
`default_nettype wire

/* verif/isx_file_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural file space; read is combinational, as the core expects
module isx_file_model (
  input wire logic sys_clk,
  input wire logic [6:0] raddr,
  input wire isx_pkg::isx_fwr_t wr,
  output logic [7:0] rdata
);
  logic [7:0] mem_q [128];
  assign rdata = mem_q[raddr];
  always @(posedge sys_clk) if (wr.we) mem_q[wr.addr] <= wr.data;
endmodule
`default_nettype wire

/* verif/isx_exec_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module isx_exec_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic insn_valid,
  input wire logic [13:0] insn,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] work_q,
  input wire isx_pkg::isx_fwr_t file_wr,
  input wire logic zero_q,
  input wire logic zero_we_q,
  input wire logic skip_q,
  input wire logic squash_q
);
  wire logic v = ce & insn_valid & ~squash_q;
  wire logic [5:0] o = insn[13:8];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  inc_skip_a: assert property (v && o == 6'h0f && file_rdata == 8'hff
    |=> skip_q && squash_q) else $error("skip");
  inc_sum_a: assert property (v && o == 6'h0f && insn[7]
    |=> file_wr.we && file_wr.data == $past(file_rdata) + 8'h01)
    else $error("sum");
  or_file_a: assert property (v && o == 6'h04 && !insn[7]
    |=> work_q == ($past(work_q) | $past(file_rdata))) else $error("orf");
  or_lit_a: assert property (v && o == 6'h38
    |=> work_q == ($past(work_q) | $past(insn[7:0])) && !file_wr.we)
    else $error("orl");
  load_lit_a: assert property (v && insn[13:10] == 4'hc
    |=> work_q == $past(insn[7:0])) else $error("load");
  or_zero_a: assert property (v && (o == 6'h38 || o == 6'h04 && !insn[7])
    |=> zero_we_q && zero_q == (work_q == 8'h00)) else $error("zero");
  flag_keep_a: assert property (v && (o == 6'h0f || insn[13:10] == 4'hc)
    |=> $stable(zero_q) && !zero_we_q) else $error("keep");
  squash_word_a: assert property (squash_q && ce && insn_valid
    |=> !squash_q && $stable(work_q) && !file_wr.we) else $error("squash");
endmodule
bind isx_exec isx_exec_properties p_u (.sys_clk, .rst, .ce, .insn_valid,
  .insn, .file_rdata, .work_q, .file_wr, .zero_q, .zero_we_q, .skip_q,
  .squash_q);
`default_nettype wire

/* verif/incskip_or_literal_exec_test.sv */
`timescale 1ns/1ps
`default_nettype none
module incskip_or_literal_exec_test;
  logic sys_clk = 0, rst = 1, ce = 1, insn_valid = 0;
  logic [13:0] insn = 14'h0000;
  logic [7:0] file_rdata, work_q;
  logic [6:0] file_raddr;
  isx_pkg::isx_fwr_t file_wr;
  logic zero_q, zero_we_q, skip_q, squash_q;
  int failures = 0, checks = 0;
  always #5 sys_clk = ~sys_clk;
  isx_exec dut_u (.sys_clk, .rst, .ce, .insn_valid, .insn, .file_rdata,
    .file_raddr, .file_wr, .work_q, .zero_q, .zero_we_q, .skip_q, .squash_q);
  isx_file_model fm_u (.sys_clk, .raddr(file_raddr), .wr(file_wr),
    .rdata(file_rdata));
  task chk(input string n, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  // result is looked at just after the edge that takes the word
  task ex(input logic [13:0] w);
    @(posedge sys_clk);
    insn <= w;
    insn_valid <= 1'h1;
    @(posedge sys_clk);
    insn_valid <= 1'h0;
    #1;
  endtask
  task t_lit;
    ex(14'h339a);
    chk("work", 8'h9a, work_q);
    ex(14'h3835);
    chk("work", 8'hbf, work_q);
    ex(14'h3000);
    ex(14'h3800);
    chk("zero", 8'h01, zero_q);
  endtask
  task t_file;
    fm_u.mem_q[7'h13] = 8'h13;
    ex(14'h3091);
    ex(14'h0413);
    chk("work", 8'h93, work_q);
    ex(14'h0493);
    chk("file", 8'h93, file_wr.data);
  endtask
  task t_skip;
    fm_u.mem_q[7'h05] = 8'hff;
    fm_u.mem_q[7'h06] = 8'h41;
    ex(14'h0f85);
    chk("skip", 8'h01, skip_q);
    chk("squash", 8'h01, squash_q);
    chk("fwe", 8'h01, file_wr.we);
    chk("faddr", 8'h05, file_wr.addr);
    chk("fdata", 8'h00, file_wr.data);
    chk("zero_we", 8'h00, zero_we_q);
    ex(14'h3055);
    chk("work", 8'h93, work_q);
    ex(14'h0f06);
    chk("work", 8'h42, work_q);
    chk("squash", 8'h00, squash_q);
  endtask
  // enable low freezes state even with a valid word standing
  task t_ce;
    ex(14'h3801);
    chk("zero_we", 8'h01, zero_we_q);
    @(posedge sys_clk);
    ce <= 1'h0;
    insn <= 14'h3055;
    insn_valid <= 1'h1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk("work", 8'h43, work_q);
    chk("raddr", 8'h55, {1'b0, file_raddr});
    @(posedge sys_clk);
    ce <= 1'h1;
    insn_valid <= 1'h0;
  endtask
  // second reset in mid-run
  task t_rst;
    ex(14'h3855);
    @(posedge sys_clk);
    rst <= 1'h1;
    @(posedge sys_clk);
    rst <= 1'h0;
    #1;
    chk("work", 8'h00, work_q);
    chk("zero", 8'h00, zero_q);
    ex(14'h3812);
    chk("work", 8'h12, work_q);
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    t_lit();
    t_file();
    t_skip();
    t_ce();
    t_rst();
    end_of_test();
  end
endmodule
`default_nettype wire
